// *** design/opc_pkg.sv ***
package opc_pkg;
	// Register offsets (printed offsets are not multiples of four: index, byte address = 4*index)
	localparam logic [15:0] OPC_IDX_SCRATCH = 16'h4009;
	localparam logic [15:0] OPC_IDX_CTRL = 16'h400a;
	localparam logic [15:0] OPC_IDX_KEY = 16'h4008;
	localparam logic [15:0] OPC_IDX_STATUS = 16'h400b;
	localparam logic [15:0] OPC_UNLOCK_VALUE = 16'h9716;
	// Control field positions
	localparam int OPC_BIT_PROG = 15;
	localparam int OPC_BIT_MEM = 13;
	localparam int OPC_BIT_FINAL = 11;
	localparam int OPC_BIT_VERIFY = 10;
	localparam int OPC_BIT_WRITE = 9;
	localparam int OPC_BIT_READ = 8;
	localparam int OPC_BIT_MARGIN_HI = 7;
	localparam int OPC_BIT_MARGIN_LO = 6;
	localparam int OPC_BIT_BULK = 5;
	localparam int OPC_BIT_PAGE_HI = 1;
	localparam int OPC_BIT_PAGE_LO = 0;
	// Reset values
	localparam logic [15:0] OPC_SCRATCH_RST = 16'h0000;
	localparam logic OPC_MEM_RST = 1'b1;
	localparam logic [1:0] OPC_MARGIN_RST = 2'h0;
	localparam logic [1:0] OPC_PAGE_RST = 2'h0;
	// Command busy time in cycles
	localparam int OPC_CMD_CYCLES = 4;
	// Margin encodings
	typedef enum logic [1:0] {
		OPC_MARGIN_NORMAL = 2'h0,
		OPC_MARGIN_RSVD = 2'h1,
		OPC_MARGIN_1 = 2'h2,
		OPC_MARGIN_2 = 2'h3
	} opc_margin_e;
	typedef enum logic [2:0] {
		OPC_CMD_NONE,
		OPC_CMD_READ,
		OPC_CMD_WRITE,
		OPC_CMD_VERIFY,
		OPC_CMD_FINAL
	} opc_cmd_e;
	// Command issued towards the memory macro
	typedef struct packed {
		logic valid;
		logic [2:0] cmd;
		logic mem_otp;
		logic all_pages;
		logic [2:0] page;
		logic [1:0] margin;
	} opc_cmd_s;
endpackage

// *** design/opc_page_map.sv ***
`timescale 1ns/1ps
module opc_page_map
	import opc_pkg::*;
(
	input wire logic mem_otp,
	input wire logic [1:0] page_code,
	output logic [2:0] page,
	output logic reserved
);
	// Translate the page code into a physical page number
	always_comb
	begin
		reserved = 1'b0;
		if (mem_otp)
		begin
			page = {1'b0, page_code};
		end
		else
		begin
			page = 3'({1'b0, page_code} + 3'h2);
			reserved = (page_code == 2'h3);
		end
	end
endmodule // opc_page_map

// *** design/opc_wb_slave.sv ***
`timescale 1ns/1ps
module opc_wb_slave
	import opc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [17:2] wb_adr_i,
	output logic wb_ack_o,
	output logic req_wr,
	output logic req_rd,
	output logic [15:0] req_idx
);
	logic ack_r;
	// Single-wait acknowledge, dropped in the cycle after it is given
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			ack_r <= 1'b0;
		else
			ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
	end
	assign wb_ack_o = ack_r;
	assign req_idx = wb_adr_i;
	// Strobes fire with the acknowledge edge
	assign req_wr = ack_r && wb_we_i;
	assign req_rd = ack_r && !wb_we_i;
endmodule // opc_wb_slave

// *** design/opc_otp_control.sv ***
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - 16-bit scratch register, no hardware effect
// - Scratch kept across battery-backup state
// - Writing 1 enters programming state
// - Programming state sticky until device reset
// - Memory select: 0 emulation, 1 one-time
// - Finalise command blocks later one-time programming
// - Verify bit starts verify command
// - Write bit starts write command
// - Read bit starts read command
// - Margin field selects read/verify sensing
// - Bulk bit: single page or all
// - One-time memory pages 0 to 3
// - Emulation pages 2 to 4, code 3 reserved
// - Key guards all fields but bulk/page
module opc_otp_control
	import opc_pkg::*;
#(
	parameter int CMD_CYCLES = OPC_CMD_CYCLES
)
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic backup_reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [17:2] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic cmd_done,
	output opc_cmd_s cmd_o,
	output logic program_state_o
);
	// Bus strobes from the slave
	logic req_wr;
	logic req_rd;
	logic [15:0] req_idx;

	// Register fields
	logic [15:0] host_scratch_word_r;
	logic key_open_r;
	logic key_open_nxt;
	logic program_state_select_r;
	logic program_state_select_nxt;
	logic mem_otp_r;
	logic [1:0] read_margin_level_r;
	logic all_pages_select_r;
	logic [1:0] page_code_r;

	// Command path state
	logic finalised_r;
	logic finalised_nxt;
	logic refused_r;
	logic busy_r;
	logic [7:0] busy_cnt_r;
	logic [7:0] busy_cnt_nxt;
	opc_cmd_s cmd_r;

	// Read path
	logic [31:0] dat_r;
	logic [31:0] dat_nxt;
	logic rd_req;

	// Decode helpers
	logic [2:0] page_phys;
	logic page_rsvd;
	logic [15:0] wdata;
	logic lo_we;
	logic hi_we;
	logic ctrl_wr;
	logic scratch_wr;
	logic key_wr;
	logic keyed_wr;
	logic [15:0] ctrl_view;
	opc_cmd_e cmd_sel;
	logic refuse_busy;
	logic refuse_state;
	logic refuse_page;
	logic refuse_final;
	logic cmd_refuse;

	// Bus slave handshake and decode
	opc_wb_slave u_slave (
		.ref_clk(ref_clk),
		.reset(reset),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_ack_o(wb_ack_o),
		.req_wr(req_wr),
		.req_rd(req_rd),
		.req_idx(req_idx)
	);

	// Page code translation
	opc_page_map u_map (
		.mem_otp(mem_otp_r),
		.page_code(page_code_r),
		.page(page_phys),
		.reserved(page_rsvd)
	);

	// Fixed error line and lane decode
	assign wb_err_o = 1'b0;
	assign wdata = wb_dat_i[15:0];
	assign lo_we = wb_sel_i[0];
	assign hi_we = wb_sel_i[1];

	// Write strobes, one per register target
	assign ctrl_wr = req_wr && (req_idx == OPC_IDX_CTRL);
	assign scratch_wr = req_wr && (req_idx == OPC_IDX_SCRATCH);
	assign key_wr = req_wr && (req_idx == OPC_IDX_KEY) && lo_we && hi_we;
	assign keyed_wr = ctrl_wr && key_open_r;

	// Read request, seen the cycle before the acknowledge
	assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i;

	// Scratch register, cleared only by the backup-domain reset
	always_ff @(posedge ref_clk)
	begin
		if (backup_reset)
			host_scratch_word_r <= OPC_SCRATCH_RST;
		else if (scratch_wr)
		begin
			if (lo_we)
				host_scratch_word_r[7:0] <= wdata[7:0];
			if (hi_we)
				host_scratch_word_r[15:8] <= wdata[15:8];
		end
	end

	// Security key: open only while the unlock value is held
	always_comb
	begin
		key_open_nxt = key_open_r;
		if (key_wr)
			key_open_nxt = (wdata == OPC_UNLOCK_VALUE);
	end

	// Key state register
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			key_open_r <= 1'b0;
		else
			key_open_r <= key_open_nxt;
	end

	// Programming state: a keyed write of one enters it, no write leaves it
	always_comb
	begin
		program_state_select_nxt = program_state_select_r;
		if (ctrl_wr && hi_we && key_open_r && wdata[OPC_BIT_PROG])
			program_state_select_nxt = 1'b1;
	end

	// Programming state register, cleared by device reset only
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			program_state_select_r <= 1'b0;
		else
			program_state_select_r <= program_state_select_nxt;
	end

	// Memory select, keyed
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			mem_otp_r <= OPC_MEM_RST;
		else if (keyed_wr && hi_we)
			mem_otp_r <= wdata[OPC_BIT_MEM];
	end

	// Read margin level, keyed
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			read_margin_level_r <= OPC_MARGIN_RST;
		else if (keyed_wr && lo_we)
			read_margin_level_r <= wdata[OPC_BIT_MARGIN_HI:OPC_BIT_MARGIN_LO];
	end

	// Bulk select, not keyed
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			all_pages_select_r <= 1'b0;
		else if (ctrl_wr && lo_we)
			all_pages_select_r <= wdata[OPC_BIT_BULK];
	end

	// Page code, not keyed
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			page_code_r <= OPC_PAGE_RST;
		else if (ctrl_wr && lo_we)
			page_code_r <= wdata[OPC_BIT_PAGE_HI:OPC_BIT_PAGE_LO];
	end

	// Command choice from the written bits, highest bit first
	always_comb
	begin
		cmd_sel = OPC_CMD_NONE;
		if (ctrl_wr && hi_we && key_open_r)
		begin
			if (wdata[OPC_BIT_FINAL])
				cmd_sel = OPC_CMD_FINAL;
			else if (wdata[OPC_BIT_VERIFY])
				cmd_sel = OPC_CMD_VERIFY;
			else if (wdata[OPC_BIT_WRITE])
				cmd_sel = OPC_CMD_WRITE;
			else if (wdata[OPC_BIT_READ])
				cmd_sel = OPC_CMD_READ;
		end
	end

	// Reasons to refuse a chosen command
	assign refuse_busy = busy_r;
	assign refuse_state = !program_state_select_r;
	assign refuse_page = !all_pages_select_r && page_rsvd;
	assign refuse_final = finalised_r && mem_otp_r
		&& (cmd_sel == OPC_CMD_WRITE || cmd_sel == OPC_CMD_FINAL);
	assign cmd_refuse = refuse_busy || refuse_state || refuse_page || refuse_final;

	// Command issue: one-cycle pulse carrying the selection of that moment
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			cmd_r <= '0;
		else
		begin
			cmd_r.valid <= 1'b0;
			if (cmd_sel != OPC_CMD_NONE && !cmd_refuse)
			begin
				cmd_r.valid <= 1'b1;
				cmd_r.cmd <= cmd_sel;
				cmd_r.mem_otp <= mem_otp_r;
				cmd_r.all_pages <= all_pages_select_r;
				cmd_r.page <= page_phys;
				cmd_r.margin <= read_margin_level_r;
			end
		end
	end

	// Refusal flag: set by a refused command, cleared by an accepted one
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			refused_r <= 1'b0;
		else if (cmd_sel != OPC_CMD_NONE)
			refused_r <= cmd_refuse;
	end

	// Busy timer: loaded by an issued command, counts down while busy
	always_comb
	begin
		busy_cnt_nxt = busy_cnt_r;
		if (cmd_r.valid)
			busy_cnt_nxt = 8'(CMD_CYCLES);
		else if (busy_r)
			busy_cnt_nxt = 8'(busy_cnt_r - 8'h01);
	end

	// Busy timer register
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			busy_cnt_r <= 8'h00;
		else
			busy_cnt_r <= busy_cnt_nxt;
	end

	// Busy until the memory reports done or the timer runs out
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			busy_r <= 1'b0;
		else if (cmd_r.valid)
			busy_r <= 1'b1;
		else if (busy_r && (cmd_done || busy_cnt_r == 8'h01))
			busy_r <= 1'b0;
	end

	// Finalise latch: set by an issued finalise on the one-time memory
	always_comb
	begin
		finalised_nxt = finalised_r;
		if (cmd_r.valid && cmd_r.cmd == OPC_CMD_FINAL && cmd_r.mem_otp)
			finalised_nxt = 1'b1;
	end

	// Finalise register, kept until device reset
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			finalised_r <= 1'b0;
		else
			finalised_r <= finalised_nxt;
	end

	// Control register as read back; command bits read as zero
	always_comb
	begin
		ctrl_view = 16'h0000;
		ctrl_view[OPC_BIT_PROG] = program_state_select_r;
		ctrl_view[OPC_BIT_MEM] = mem_otp_r;
		ctrl_view[OPC_BIT_MARGIN_HI:OPC_BIT_MARGIN_LO] = read_margin_level_r;
		ctrl_view[OPC_BIT_BULK] = all_pages_select_r;
		ctrl_view[OPC_BIT_PAGE_HI:OPC_BIT_PAGE_LO] = page_code_r;
	end

	// Read data selection by register index
	always_comb
	begin
		dat_nxt = 32'h0000_0000;
		unique case (wb_adr_i)
			OPC_IDX_SCRATCH: dat_nxt = {16'h0000, host_scratch_word_r};
			OPC_IDX_CTRL: dat_nxt = {16'h0000, ctrl_view};
			OPC_IDX_KEY: dat_nxt = {31'h0000_0000, key_open_r};
			OPC_IDX_STATUS: dat_nxt = {28'h000_0000, refused_r, finalised_r, busy_r, program_state_select_r};
			default: dat_nxt = 32'h0000_0000;
		endcase
	end

	// Read data, registered on the same edge that raises the acknowledge
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			dat_r <= 32'h0000_0000;
		else if (rd_req)
			dat_r <= dat_nxt;
	end
	assign wb_dat_o = dat_r;

	assign cmd_o = cmd_r;
	assign program_state_o = program_state_select_r;
endmodule // opc_otp_control

// *** test/opc_otp_control_asserts.sv ***
`timescale 1ns/1ps
module opc_ctrl_chk
	import opc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [17:2] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire opc_cmd_s cmd_o,
	input wire logic program_state_o
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// Accepted control register write
	wire logic wr_ctrl = wb_ack_o && wb_we_i && wb_adr_i == OPC_IDX_CTRL;
	// Bus answer, programming state and command checks
	a_ack_single: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a one cycle answer");
	a_prog_sticky: assert property (program_state_o |=> program_state_o)
		else $error("programming state dropped");
	a_prog_cause: assert property ($rose(program_state_o) |-> $past(wr_ctrl && wb_dat_i[OPC_BIT_PROG]))
		else $error("programming state without write of one");
	a_cmd_cause: assert property (cmd_o.valid |-> $past(wr_ctrl && |wb_dat_i[11:8]))
		else $error("command without command write");
	a_cmd_pulse: assert property (cmd_o.valid |=> !cmd_o.valid)
		else $error("command valid longer than one cycle");
	a_otp_page: assert property (cmd_o.valid && cmd_o.mem_otp && !cmd_o.all_pages |-> cmd_o.page <= 3'h3)
		else $error("one-time page out of range");
	a_ice_page: assert property (cmd_o.valid && !cmd_o.mem_otp && !cmd_o.all_pages |-> cmd_o.page inside {3'h2, 3'h3, 3'h4})
		else $error("emulation page out of range");
	a_cmd_readback: assert property (wb_ack_o && !wb_we_i && wb_adr_i == OPC_IDX_CTRL |-> wb_dat_o[11:8] == 4'h0)
		else $error("command bits read back set");
	// Main scenarios
	cover property (cmd_o.valid && cmd_o.cmd == OPC_CMD_FINAL);
	cover property ($rose(program_state_o));
	cover property (cmd_o.valid && !cmd_o.mem_otp);
endmodule // opc_ctrl_chk

// *** test/opc_mem_model.sv ***
`timescale 1ns/1ps
module opc_mem_model
	import opc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic slow,
	input wire opc_cmd_s cmd_i,
	output logic cmd_done
);
	logic [3:0] wait_r;
	// Macro finishes a command after a short or a long delay
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			wait_r <= 4'h0;
		else if (cmd_i.valid)
			wait_r <= slow ? 4'h6 : 4'h1;
		else if (wait_r != 4'h0)
			wait_r <= wait_r - 4'h1;
	end
	assign cmd_done = (wait_r == 4'h1); // One cycle completion
endmodule // opc_mem_model

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
	import opc_pkg::*;
;
	logic ref_clk = 1'b0, reset = 1'b1, backup_reset = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic slow = 1'b0, wb_ack_o, cmd_done, program_state_o;
	logic [15:0] wb_adr_i = 16'h0000, q, sv, cw;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
	logic [1:0] mg;
	opc_cmd_s cmd_o;
	opc_cmd_s exp_q[$];
	int miscompares = 0, check_count = 0, seed = 32'h0000_cc56;
	// Clock
	always #10 ref_clk = ~ref_clk;
	opc_otp_control #(.CMD_CYCLES(4)) u_opc_otp_control (.ref_clk(ref_clk), .reset(reset),
		.backup_reset(backup_reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(4'h3), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.wb_err_o(), .cmd_done(cmd_done), .cmd_o(cmd_o), .program_state_o(program_state_o));
	opc_mem_model u_opc_mem_model (.ref_clk(ref_clk), .reset(reset), .slow(slow), .cmd_i(cmd_o),
		.cmd_done(cmd_done));
	task automatic complete_run;
		if (miscompares == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Classic single Wishbone cycle, held until ack
	task automatic wb(input logic we, input logic [15:0] a, input logic [15:0] d, output logic [15:0] rd);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {16'h0000, d};
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 50);
		if (n == 50)
			miscompares++;
		rd = wb_dat_o[15:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge ref_clk);
	endtask
	// Every issued command must match the next expected one
	always @(posedge ref_clk)
		if (cmd_o.valid === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk("cmd_o", {21'h00_0000, cmd_o}, 32'h0000_0000);
			else
				chk("cmd_o", {21'h00_0000, cmd_o}, {21'h00_0000, exp_q.pop_front()});
		end
	// Watchdog
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		miscompares++;
		complete_run;
	end
	// Main sequence
	initial
	begin
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		backup_reset <= 1'b0;
		@(posedge ref_clk);
		wb(1'b0, OPC_IDX_CTRL, 16'h0000, q);
		chk("ctrl_rst", q, 16'h2000);
		wb(1'b0, OPC_IDX_SCRATCH, 16'h0000, q);
		chk("scr_rst", q, OPC_SCRATCH_RST);
		sv = 16'($random(seed));
		wb(1'b1, OPC_IDX_SCRATCH, sv, q);
		wb(1'b1, OPC_IDX_CTRL, 16'h8020, q);
		wb(1'b0, OPC_IDX_CTRL, 16'h0000, q);
		chk("ctrl_lock", q, 16'h2020);
		chk("prog_lock", program_state_o, 1'b0);
		wb(1'b1, OPC_IDX_KEY, OPC_UNLOCK_VALUE, q);
		wb(1'b1, OPC_IDX_CTRL, 16'h8000, q);
		wb(1'b1, OPC_IDX_CTRL, 16'h2000, q);
		chk("prog_keep", program_state_o, 1'b1);
		for (int m = 0; m < 2; m++)
			for (int p = 0; p < 4; p++)
				for (int c = 1; c < 4; c++)
				begin
					mg = 2'($random(seed));
					if (mg == 2'h1)
						mg = 2'h2;
					slow <= mg[1];
					cw = {2'b00, m[0], 5'h00, mg, 4'h0, p[1:0]};
					wb(1'b1, OPC_IDX_CTRL, cw, q);
					if (m == 1 || p != 3)
						exp_q.push_back({1'b1, c[2:0], m[0], 1'b0, m[0] ? p[2:0] : p[2:0] + 3'h2, mg});
					wb(1'b1, OPC_IDX_CTRL, cw | (16'h0080 << c), q);
					repeat (8) @(posedge ref_clk);
				end
		wb(1'b1, OPC_IDX_CTRL, 16'h2000, q);
		exp_q.push_back({1'b1, 3'h4, 1'b1, 1'b0, 3'h0, 2'h0});
		wb(1'b1, OPC_IDX_CTRL, 16'h2800, q);
		repeat (8) @(posedge ref_clk);
		wb(1'b1, OPC_IDX_CTRL, 16'h2200, q);
		repeat (8) @(posedge ref_clk);
		exp_q.push_back({1'b1, 3'h1, 1'b1, 1'b0, 3'h0, 2'h0});
		wb(1'b1, OPC_IDX_CTRL, 16'h2100, q);
		repeat (8) @(posedge ref_clk);
		wb(1'b0, OPC_IDX_CTRL, 16'h0000, q);
		chk("ctrl_cmd", q, 16'ha000);
		wb(1'b1, OPC_IDX_CTRL, 16'h8020, q);
		exp_q.push_back({1'b1, 3'h1, 1'b0, 1'b1, 3'h2, 2'h0});
		wb(1'b1, OPC_IDX_CTRL, 16'h8120, q);
		repeat (8) @(posedge ref_clk);
		chk("pending", exp_q.size(), 32'h0000_0000);
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		chk("prog_rst", program_state_o, 1'b0);
		wb(1'b0, OPC_IDX_SCRATCH, 16'h0000, q);
		chk("scr_keep", q, sv);
		complete_run;
	end
endmodule // tb_top
bind opc_otp_control opc_ctrl_chk u_opc_ctrl_chk (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .cmd_o(cmd_o), .program_state_o(program_state_o));
